// ---- logic/dac_link_params.svh ----
`ifndef DAC_LINK_PARAMS_SVH
`define DAC_LINK_PARAMS_SVH

// Frame layout, counted from bit 15 which is shifted in first.
`define FRAME_BITS 16
`define MODE_HI_POS 13
`define MODE_LO_POS 12
`define CODE_MSB_POS 11
`define CODE_LSB_POS 4
// Reset values.
`define CODE_RESET 8'h00
`define MODE_RESET 2'h0
// Least frame select high time in ns, and its count of 4 ns cycles rounded up.
`define SEL_HIGH_MIN_NS 33
`define REF_CLK_PERIOD_NS 4
`define SEL_HIGH_CYCLES ((`SEL_HIGH_MIN_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
// Recovery after power-down in ns, typical at 5 V and at 3 V, with cycle counts.
`define WAKE_5V_NS 2500
`define WAKE_3V_NS 5000
`define WAKE_5V_CYCLES (`WAKE_5V_NS / `REF_CLK_PERIOD_NS)
`define WAKE_3V_CYCLES (`WAKE_3V_NS / `REF_CLK_PERIOD_NS)
// Half period of the link clock made by the host, in ref_clk cycles.
`define LINK_HALF_CYCLES 6

`endif

// ---- logic/dac_link_pkg.sv ----
package dac_link_pkg;

  typedef enum logic [1:0] {
    mode_normal,
    mode_pd_1k,
    mode_pd_100k,
    mode_pd_open
  } out_mode_e;

  typedef enum logic [1:0] {
    dev_wait_high,
    dev_idle,
    dev_shift,
    dev_done
  } dev_state_e;

  typedef enum logic [2:0] {
    host_idle,
    host_gap,
    host_setup,
    host_low,
    host_high,
    host_tail
  } host_state_e;

endpackage : dac_link_pkg

// ---- logic/dac_link_if.sv ----
interface dac_link_if;
  logic frame_sel_n;
  logic sclk;
  logic sdata;

  modport host (
    output frame_sel_n,
    output sclk,
    output sdata
  );

  modport device (
    input frame_sel_n,
    input sclk,
    input sdata
  );
endinterface : dac_link_if

// ---- logic/dac_device.sv ----
`include "dac_link_params.svh"

// Overview of operation
// - Host starts frame by lowering frame select.
// - Shift data on falling clock while selected.
// - Sixteenth falling edge executes the frame.
// - Host keeps select high 33 ns between frames.
// - Host may park select low between writes.
// - Frame: two ignored, mode, code, four ignored.
// - Mode bits are frame bits 13 and 12.
// - Mode 00 normal, 01/10/11 power-down terminations.
// - Early select rise discards the frame.
// - Reset clears code, output held at zero.
// - Power-down frame also loads its code, selects termination.
// - Output valid only after wake-up recovery.
// - Code is straight binary 0 to 255.
// - Host sends most significant bit first.
module dac_device #(
  parameter int FRAME_BITS = `FRAME_BITS,
  parameter int WAKE_CYCLES = `WAKE_5V_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  dac_link_if.device link,
  output logic [7:0] dac_code,
  output dac_link_pkg::out_mode_e out_mode,
  output logic amp_enable,
  output logic out_valid,
  output logic frame_done,
  output logic frame_aborted
);

  // =====================================================================
  // Widths and end points
  localparam int CNT_W = $clog2(FRAME_BITS + 1);
  localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_BITS - 1);
  localparam logic [WAKE_W-1:0] WAKE_END = WAKE_W'(WAKE_CYCLES);

  // =====================================================================
  // State
  typedef struct packed {
    // Two-flop synchronisers and one stage of edge history.
    logic [1:0] sel_sync;
    logic [1:0] clk_sync;
    logic [1:0] dat_sync;
    logic sel_last;
    logic clk_last;
    logic dat_last;
    // Frame assembly.
    dac_link_pkg::dev_state_e state;
    logic [FRAME_BITS-1:0] shift;
    logic [CNT_W-1:0] count;
    // Converter settings kept between frames.
    logic [7:0] code;
    dac_link_pkg::out_mode_e mode;
    logic written;
    // Output recovery and strobes.
    logic [WAKE_W-1:0] wake;
    logic amp;
    logic valid;
    logic done;
    logic aborted;
  } dev_s;

  // Select reads high after reset, so dev_wait_high passes at once and a select held low through reset is seen to fall and starts a frame.
  localparam dev_s RESET_ST = '{
    sel_sync: 2'h3,
    clk_sync: 2'h0,
    dat_sync: 2'h0,
    sel_last: 1'b1,
    clk_last: 1'b0,
    dat_last: 1'b0,
    state: dac_link_pkg::dev_wait_high,
    shift: '0,
    count: '0,
    code: `CODE_RESET,
    mode: dac_link_pkg::out_mode_e'(`MODE_RESET),
    written: 1'b0,
    wake: '0,
    amp: 1'b0,
    valid: 1'b0,
    done: 1'b0,
    aborted: 1'b0
  };

  dev_s st_reg;
  dev_s st_next;

  logic sel_n;
  logic clk_fall;
  logic sel_fall;
  logic sel_rise;
  logic [FRAME_BITS-1:0] frame_in;
  logic frame_full;

  // =====================================================================
  // Field decoding
  function automatic logic [7:0] frame_code(input logic [FRAME_BITS-1:0] frame);
    frame_code = frame[`CODE_MSB_POS:`CODE_LSB_POS];
  endfunction : frame_code

  function automatic dac_link_pkg::out_mode_e frame_mode(input logic [FRAME_BITS-1:0] frame);
    frame_mode = dac_link_pkg::out_mode_e'({frame[`MODE_HI_POS], frame[`MODE_LO_POS]});
  endfunction : frame_mode

  // Any power-down mode turns the amplifier off, whatever the code holds.
  function automatic logic is_driving(input logic written, input dac_link_pkg::out_mode_e mode);
    is_driving = written && (mode == dac_link_pkg::mode_normal);
  endfunction : is_driving

  // =====================================================================
  // Link sampling
  // The host may move data in the same instant as the falling link clock, so the bit
  // is taken from the cycle before the fall shows at the synchroniser output.
  assign sel_n = st_reg.sel_sync[1];
  assign clk_fall = st_reg.clk_last && !st_reg.clk_sync[1];
  assign sel_fall = st_reg.sel_last && !sel_n;
  assign sel_rise = !st_reg.sel_last && sel_n;
  assign frame_in = {st_reg.shift[FRAME_BITS-2:0], st_reg.dat_last};
  assign frame_full = (st_reg.count == LAST_BIT);

  // =====================================================================
  // Frame engine
  always_comb begin
    st_next = st_reg;
    st_next.sel_sync = {st_reg.sel_sync[0], link.frame_sel_n};
    st_next.clk_sync = {st_reg.clk_sync[0], link.sclk};
    st_next.dat_sync = {st_reg.dat_sync[0], link.sdata};
    st_next.sel_last = sel_n;
    st_next.clk_last = st_reg.clk_sync[1];
    st_next.dat_last = st_reg.dat_sync[1];
    st_next.done = 1'b0;
    st_next.aborted = 1'b0;
    unique case (st_reg.state)
      dac_link_pkg::dev_wait_high: begin
        if (sel_n) begin
          st_next.state = dac_link_pkg::dev_idle;
        end
      end
      dac_link_pkg::dev_idle: begin
        if (sel_fall) begin
          st_next.state = dac_link_pkg::dev_shift;
          st_next.count = '0;
          st_next.shift = '0;
        end
      end
      dac_link_pkg::dev_shift: begin
        if (sel_rise) begin
          // An early rise discards what was shifted and changes nothing.
          st_next.state = dac_link_pkg::dev_idle;
          st_next.shift = '0;
          st_next.count = '0;
          st_next.aborted = 1'b1;
        end else if (clk_fall) begin
          // First bit in lands at bit 15 once the frame is full.
          st_next.shift = frame_in;
          st_next.count = st_reg.count + CNT_W'(1);
          if (frame_full) begin
            st_next.code = frame_code(frame_in);
            st_next.mode = frame_mode(frame_in);
            st_next.written = 1'b1;
            st_next.done = 1'b1;
            st_next.state = dac_link_pkg::dev_done;
          end
        end
      end
      dac_link_pkg::dev_done: begin
        // Further clocks are ignored until select has been high again.
        if (sel_n) begin
          st_next.state = dac_link_pkg::dev_idle;
        end
      end
    endcase
    // Output recovers only after staying in normal mode for the wake time.
    st_next.amp = is_driving(st_next.written, st_next.mode);
    if (!is_driving(st_next.written, st_next.mode)) begin
      st_next.wake = '0;
      st_next.valid = 1'b0;
    end else if (st_reg.wake != WAKE_END) begin
      st_next.wake = st_reg.wake + WAKE_W'(1);
      st_next.valid = 1'b0;
    end else begin
      st_next.valid = 1'b1;
    end
  end

  // =====================================================================
  // Register update
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= RESET_ST;
    end else begin
      st_reg <= st_next;
    end
  end

  // =====================================================================
  // Outputs
  assign dac_code = st_reg.code;
  assign out_mode = st_reg.mode;
  assign amp_enable = st_reg.amp;
  assign out_valid = st_reg.valid;
  assign frame_done = st_reg.done;
  assign frame_aborted = st_reg.aborted;

endmodule : dac_device

// ---- logic/dac_host.sv ----
`include "dac_link_params.svh"

module dac_host #(
  parameter int FRAME_BITS = `FRAME_BITS,
  parameter int HALF_CYCLES = `LINK_HALF_CYCLES,
  parameter int GAP_CYCLES = `SEL_HIGH_CYCLES,
  parameter bit PARK_LOW = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  dac_link_if.host link,
  input wire logic req_valid,
  input wire logic [7:0] req_code,
  input wire logic [1:0] req_mode,
  output logic req_ready,
  output logic req_done
);

  localparam int CNT_W = $clog2(FRAME_BITS + 1);
  localparam int DIV_W = $clog2(HALF_CYCLES + GAP_CYCLES + 1);

  typedef struct packed {
    dac_link_pkg::host_state_e state;
    logic [FRAME_BITS-1:0] shift;
    logic [CNT_W-1:0] count;
    logic [DIV_W-1:0] div;
    logic sel_n;
    logic sclk;
    logic sdata;
    logic ready;
    logic done;
  } host_s;

  host_s st_reg;
  host_s st_next;

  // =====================================================================
  // Frame sender
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    unique case (st_reg.state)
      dac_link_pkg::host_idle: begin
        if (req_valid && st_reg.ready) begin
          st_next.shift = '0;
          st_next.shift[`MODE_HI_POS:`MODE_LO_POS] = req_mode;
          st_next.shift[`CODE_MSB_POS:`CODE_LSB_POS] = req_code;
          st_next.ready = 1'b0;
          st_next.sel_n = 1'b1;
          st_next.div = '0;
          st_next.state = dac_link_pkg::host_gap;
        end
      end
      dac_link_pkg::host_gap: begin
        // Select stays high long enough before each new frame.
        if (st_reg.div == DIV_W'(GAP_CYCLES)) begin
          st_next.sel_n = 1'b0;
          st_next.sdata = st_reg.shift[FRAME_BITS-1];
          st_next.count = '0;
          st_next.div = '0;
          st_next.state = dac_link_pkg::host_setup;
        end else begin
          st_next.div = st_reg.div + DIV_W'(1);
        end
      end
      dac_link_pkg::host_setup, dac_link_pkg::host_low: begin
        if (st_reg.div == DIV_W'(HALF_CYCLES - 1)) begin
          st_next.div = '0;
          st_next.sclk = 1'b1;
          st_next.state = dac_link_pkg::host_high;
        end else begin
          st_next.div = st_reg.div + DIV_W'(1);
        end
      end
      dac_link_pkg::host_high: begin
        if (st_reg.div == DIV_W'(HALF_CYCLES - 1)) begin
          st_next.div = '0;
          st_next.sclk = 1'b0;
          st_next.count = st_reg.count + CNT_W'(1);
          st_next.shift = {st_reg.shift[FRAME_BITS-2:0], 1'b0};
          if (st_reg.count == CNT_W'(FRAME_BITS - 1)) begin
            st_next.state = dac_link_pkg::host_tail;
          end else begin
            st_next.sdata = st_reg.shift[FRAME_BITS-2];
            st_next.state = dac_link_pkg::host_low;
          end
        end else begin
          st_next.div = st_reg.div + DIV_W'(1);
        end
      end
      dac_link_pkg::host_tail: begin
        if (st_reg.div == DIV_W'(HALF_CYCLES - 1)) begin
          st_next.div = '0;
          st_next.sel_n = !PARK_LOW;
          st_next.sdata = 1'b0;
          st_next.ready = 1'b1;
          st_next.done = 1'b1;
          st_next.state = dac_link_pkg::host_idle;
        end else begin
          st_next.div = st_reg.div + DIV_W'(1);
        end
      end
      default: begin
        st_next.state = dac_link_pkg::host_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.sel_n <= 1'b1;
      st_reg.ready <= 1'b1;
      st_reg.state <= dac_link_pkg::host_idle;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.frame_sel_n = st_reg.sel_n;
  assign link.sclk = st_reg.sclk;
  assign link.sdata = st_reg.sdata;
  assign req_ready = st_reg.ready;
  assign req_done = st_reg.done;

endmodule : dac_host

// ---- verification/dac_link_checker.sv ----
// ==========
// Checks of the link and of the converter outputs.
module dac_link_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic [7:0] dac_code,
  input wire dac_link_pkg::out_mode_e out_mode,
  input wire logic amp_enable,
  input wire logic out_valid,
  input wire logic frame_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sd_reg;
  logic [4:0] nf_reg;
  logic [15:0] sh_reg;
  // Data changes with the falling link clock, so the bit is taken from the cycle before.
  always_ff @(posedge ref_clk) begin
    sd_reg <= sdata;
    if (rst || frame_sel_n) nf_reg <= 5'h00;
    else if ($fell(sclk) && nf_reg != 5'h1f) nf_reg <= nf_reg + 5'h01;
    if ($fell(sclk)) sh_reg <= {sh_reg[14:0], sd_reg};
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_code_hold; !frame_done |-> $stable(dac_code); endproperty
  a_code_hold: assert property (p_code_hold) else $error("code changed without a frame");
  property p_mode_hold; !frame_done |-> $stable(out_mode); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed without a frame");
  property p_exec; $fell(sclk) && !frame_sel_n && nf_reg == 5'h0f |-> ##[1:6] frame_done; endproperty
  a_exec: assert property (p_exec) else $error("frame not executed");
  property p_done_cnt; frame_done |-> nf_reg == 5'h10; endproperty
  a_done_cnt: assert property (p_done_cnt) else $error("frame done at wrong edge count");
  property p_pulse; frame_done |=> !frame_done; endproperty
  a_pulse: assert property (p_pulse) else $error("frame done too long");
  property p_code_wire; frame_done |-> dac_code == sh_reg[11:4]; endproperty
  a_code_wire: assert property (p_code_wire) else $error("code differs from frame");
  property p_mode_wire; frame_done |-> out_mode == sh_reg[13:12]; endproperty
  a_mode_wire: assert property (p_mode_wire) else $error("mode differs from frame");
  property p_amp; amp_enable |-> out_mode == dac_link_pkg::mode_normal; endproperty
  a_amp: assert property (p_amp) else $error("amplifier on in power-down");
  property p_valid; out_valid |-> amp_enable; endproperty
  a_valid: assert property (p_valid) else $error("output valid while off");
  property p_wake; $rose(amp_enable) |-> !out_valid [*8]; endproperty
  a_wake: assert property (p_wake) else $error("output valid before recovery");
  property p_gap; $rose(frame_sel_n) |-> frame_sel_n [*8] ##1 frame_sel_n; endproperty
  a_gap: assert property (p_gap) else $error("select high time too short");
endmodule : dac_link_checker

// ---- verification/tb.sv ----
// ==========
// Host and device joined on one link, a bench driver on a second.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic [7:0] req_code = 8'h00;
  logic [1:0] req_mode = 2'h0;
  logic req_ready, req_done, amp_enable, out_valid, frame_done, b_done, b_abort, sd_reg, sk_reg;
  logic [7:0] dac_code, b_code;
  dac_link_pkg::out_mode_e out_mode, b_mode;
  logic [15:0] word_reg;
  int nfall = 0, b_dones = 0, b_aborts = 0, errors = 0, cmp_count = 0, cyc = 0;
  // Rows: mode, code, expected amplifier enable.
  localparam logic [10:0] rows[6] = '{11'h14b, 11'h34a, 11'h54a, 11'h74a, 11'h1ff, 11'h001};
  dac_link_if link_a ();
  dac_link_if link_b ();
  always #2 ref_clk = ~ref_clk;
  dac_host i_dac_host (.ref_clk(ref_clk), .rst(rst), .link(link_a.host), .req_valid(req_valid),
    .req_code(req_code), .req_mode(req_mode), .req_ready(req_ready), .req_done(req_done));
  dac_device #(.WAKE_CYCLES(10)) i_dac_device (.ref_clk(ref_clk), .rst(rst), .link(link_a.device),
    .dac_code(dac_code), .out_mode(out_mode), .amp_enable(amp_enable), .out_valid(out_valid),
    .frame_done(frame_done), .frame_aborted());
  dac_device #(.WAKE_CYCLES(10)) i_dac_device_b (.ref_clk(ref_clk), .rst(rst), .link(link_b.device),
    .dac_code(b_code), .out_mode(b_mode), .amp_enable(), .out_valid(), .frame_done(b_done),
    .frame_aborted(b_abort));
  dac_link_checker i_dac_link_checker (.ref_clk(ref_clk), .rst(rst), .frame_sel_n(link_a.frame_sel_n),
    .sclk(link_a.sclk), .sdata(link_a.sdata), .dac_code(dac_code), .out_mode(out_mode),
    .amp_enable(amp_enable), .out_valid(out_valid), .frame_done(frame_done));
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    sd_reg <= link_a.sdata;
    sk_reg <= link_a.sclk;
    if (link_a.frame_sel_n) begin
      word_reg <= 16'h0000;
      nfall <= 0;
    end else if (sk_reg && !link_a.sclk) begin
      word_reg <= {word_reg[14:0], sd_reg};
      nfall <= nfall + 1;
    end
    if (b_done === 1'b1) b_dones <= b_dones + 1;
    if (b_abort === 1'b1) b_aborts <= b_aborts + 1;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic host_write(logic [1:0] m, logic [7:0] c, logic amp);
    int n = 0;
    while (req_ready !== 1'b1 && n < 500) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("ready wait", 16'(n >= 500), 16'h0000);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_mode <= m;
    req_code <= c;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 0;
    while (req_done !== 1'b1 && n < 500) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("done wait", 16'(n >= 500), 16'h0000);
    chk("wire word", word_reg, {2'b00, m, c, 4'h0});
    chk("falls", 16'(nfall), 16'h0010);
    chk("parked select", 16'(link_a.frame_sel_n), 16'h0000);
    repeat (16) @(posedge ref_clk);
    #1 chk("code", 16'(dac_code), 16'(c));
    chk("mode", 16'(out_mode), 16'(m));
    chk("amp", 16'(amp_enable), 16'(amp));
    chk("valid", 16'(out_valid), 16'(amp));
  endtask : host_write
  task automatic b_send(logic [31:0] w, int nb, logic rel);
    @(posedge ref_clk);
    link_b.frame_sel_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    link_b.frame_sel_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      link_b.sdata <= w[31 - i];
      repeat (6) @(posedge ref_clk);
      link_b.sclk <= 1'b1;
      repeat (6) @(posedge ref_clk);
      link_b.sclk <= 1'b0;
    end
    repeat (6) @(posedge ref_clk);
    if (rel) link_b.frame_sel_n <= 1'b1;
    link_b.sdata <= ~link_b.sdata;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : b_send
  initial begin
    link_b.frame_sel_n = 1'b1;
    link_b.sclk = 1'b0;
    link_b.sdata = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("reset code", 16'(dac_code), 16'h0000);
    chk("reset valid", 16'(out_valid), 16'h0000);
    chk("idle select", 16'(link_a.frame_sel_n), 16'h0001);
    foreach (rows[i]) host_write(rows[i][10:9], rows[i][8:1], rows[i][0]);
    b_send(32'h03c00000, 16, 1'b1);
    chk("b code", 16'(b_code), 16'h003c);
    b_send(32'h1c300000, 8, 1'b1);
    chk("b aborts", 16'(b_aborts), 16'h0001);
    chk("b code kept", 16'(b_code), 16'h003c);
    chk("b mode kept", 16'(b_mode), 16'h0000);
    b_send(32'h25a03ff0, 32, 1'b0);
    chk("b dones", 16'(b_dones), 16'h0002);
    chk("b code", 16'(b_code), 16'h005a);
    chk("b mode", 16'(b_mode), 16'h0002);
    b_send(32'h08100000, 16, 1'b1);
    chk("b dones", 16'(b_dones), 16'h0003);
    chk("b code", 16'(b_code), 16'h0081);
    // A second reset in mid-run clears both converters, then a write must land again.
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("rerun code", 16'(b_code), 16'h0000);
    chk("rerun mode", 16'(b_mode), 16'h0000);
    chk("rerun valid", 16'(out_valid), 16'h0000);
    chk("rerun select", 16'(link_a.frame_sel_n), 16'h0001);
    host_write(2'h0, 8'h3c, 1'b1);
    report_and_stop();
  end
endmodule : tb
